// [verilog/utx_regs.svh]
`ifndef UTX_REGS_SVH
`define UTX_REGS_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define UTX_OFS_DATA     8'h00
`define UTX_OFS_STATUS   8'h04
`define UTX_OFS_CONTROL  8'h08
`define UTX_OFS_FORMAT   8'h0C
`define UTX_OFS_BAUD     8'h10

// ************************************************************
// Field positions
// ************************************************************
`define UTX_STAT_ACTIVE  0
`define UTX_STAT_DOUBLE  1
`define UTX_STAT_EMPTY   5
`define UTX_STAT_DONE    6
`define UTX_CTL_NINTH    0
`define UTX_CTL_TRANSMITTER_ENABLE     3
`define UTX_CTL_EMPTYIE  5
`define UTX_CTL_DONEIE   6

// ************************************************************
// Reset values and codes
// ************************************************************
`define UTX_CTL_RESET    8'h00
`define UTX_FMT_RESET    9'h003
`define UTX_BAUD_RESET   12'h000
`define UTX_SIZE_NINE    3'h7

`endif

// [verilog/utx_pkg.sv]
package utx_pkg;

   // ************************************************************
   // Bus carriers
   // ************************************************************
   typedef struct packed {
      logic        cyc;    // Cycle in progress
      logic        stb;    // Strobe
      logic        we;     // Write when high
      logic [7:0]  adr;    // Byte address
      logic [3:0]  sel;    // Byte lanes
      logic [31:0] dat;    // Write data
   } utx_wbreq_t;

   typedef struct packed {
      logic        ack;    // Single cycle acknowledge
      logic [31:0] dat;    // Read data
   } utx_wbrsp_t;

   // Frame format, laid out as the format register bits 8:0
   typedef struct packed {
      logic       master;  // Sync clock made here
      logic       pol;     // Clock polarity bit
      logic       sync;    // Synchronous operation
      logic [1:0] parity;  // Parity mode, upper bit enables
      logic       stop;    // Stop bit select
      logic [2:0] size;    // Character size code
   } utx_fmt_t;

   // Transmit sequencer states
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_START  = 3'b001,
      ST_DATA   = 3'b010,
      ST_PARITY = 3'b011,
      ST_STOP1  = 3'b100,
      ST_STOP2  = 3'b101
   } utx_state_t;

endpackage : utx_pkg

// [verilog/utx_baud.sv]
`timescale 1ns/1ps

module utx_baud (
   input  wire logic             sys_clk,
   input  wire logic             sys_rst,
   input  wire logic [11:0]      divisor,
   input  wire logic             divisorLoad,
   input  wire logic             doubleSpeed,
   input  wire utx_pkg::utx_fmt_t fmt,
   input  wire logic             xckPin,
   output logic                  xckOut,
   output logic                  xckOe,
   output logic                  bitTick
);
   import utx_pkg::*;

   logic [11:0] baudCnt_ff;    // Down counter at system clock
   logic [3:0]  preCnt_ff;     // Divide by 16 or 8
   logic        xckPhase_ff;   // Master clock level
   logic        xckS1_ff;      // Sync stage one
   logic        xckS2_ff;      // Sync stage two
   logic        xckS3_ff;      // Edge history
   logic        bitTick_ff;    // Registered bit pulse
   logic        baudTick;      // Counter reached zero
   logic        asyncTick;     // Asynchronous bit edge
   logic        masterTick;    // Change edge, master
   logic        slaveTick;     // Change edge, slave
   logic [3:0]  preLimit;      // Last prescale count

   // ************************************************************
   // Baud rate counter
   // ************************************************************
   assign baudTick = (baudCnt_ff == 12'h000);

   // Reload on zero or when software writes the divisor
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         baudCnt_ff <= 12'h000;
      end else if (divisorLoad || baudTick) begin
         baudCnt_ff <= divisor;
      end else begin
         baudCnt_ff <= baudCnt_ff - 12'h001;
      end
   end

   // ************************************************************
   // Asynchronous prescaler
   // ************************************************************
   assign preLimit  = doubleSpeed ? 4'h7 : 4'hF;                // R23
   assign asyncTick = baudTick && (preCnt_ff == preLimit);     // R23

   // Counts baud ticks, wraps at the mode limit
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         preCnt_ff <= 4'h0;
      end else if (asyncTick) begin
         preCnt_ff <= 4'h0;
      end else if (baudTick) begin
         preCnt_ff <= (preCnt_ff == preLimit) ? 4'h0 : preCnt_ff + 4'h1;
      end
   end

   // ************************************************************
   // Synchronous master clock, divide by two
   // ************************************************************
   // Data changes when the toggle reaches the polarity's change edge
   assign masterTick = baudTick && (xckPhase_ff == fmt.pol);   // R23 R24

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         xckPhase_ff <= 1'b0;
      end else if (baudTick) begin
         xckPhase_ff <= ~xckPhase_ff;
      end
   end

   // ************************************************************
   // Synchronous slave clock from the pin
   // ************************************************************
   // Two stages before any logic; third only for edges
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         xckS1_ff <= 1'b0;
         xckS2_ff <= 1'b0;
         xckS3_ff <= 1'b0;
      end else begin
         xckS1_ff <= xckPin;
         xckS2_ff <= xckS1_ff;
         xckS3_ff <= xckS2_ff;
      end
   end

   // Rising edge with polarity zero, falling with one
   assign slaveTick = fmt.pol ? (xckS3_ff && !xckS2_ff)
                              : (xckS2_ff && !xckS3_ff);       // R4 R24

   // ************************************************************
   // Bit pulse select
   // ************************************************************
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         bitTick_ff <= 1'b0;
      end else if (fmt.sync) begin
         bitTick_ff <= fmt.master ? masterTick : slaveTick;    // R4 R7
      end else begin
         bitTick_ff <= asyncTick;                              // R7
      end
   end

   assign bitTick = bitTick_ff;
   assign xckOut  = xckPhase_ff;
   assign xckOe   = fmt.sync && fmt.master;                    // R4

endmodule : utx_baud

// [verilog/utx_transmitter.sv]
// Contract
// R1: Parity is XOR of data, inverted when odd
// R2: Parity goes after data, before stop
// R3: Enabled transmitter drives the serial output pin
// R4: Synchronous mode shifts on the serial clock pin
// R5: Data register write loads buffer, starts sending
// R6: Buffer moves to shifter when idle or after stop
// R7: Shifter sends one frame at the bit rate
// R8: Unused high bits of small characters ignored
// R9: Software writes ninth bit before the low byte
// R10: Buffer-empty flag set exactly while buffer empty
// R11: Data register write clears buffer-empty flag
// R12: Buffer-empty request while enabled and flag set
// R13: Software writes zero to buffer-empty bit
// R14: Done flag sets when frame out, buffer empty
// R15: Done flag cleared by interrupt or written one
// R16: Done request when enabled and flag set
// R17: Disable waits until shifter and buffer empty
// R18: After disable, pin returns to port control
// R19: Software sets format before sending, never during
// R20: Polling software clears done flag before writes
// R21: Software masks interrupts during setup
// R22: Frame is start, data LSB first, parity, stops
// R23: Bit clock is baud output over 16, 8, 2
// R24: Data changes on edge chosen by polarity
// R25: Reset leaves buffer empty, done flag clear
`timescale 1ns/1ps
`include "utx_regs.svh"

module utx_transmitter (
   input  wire logic               sys_clk,
   input  wire logic               sys_rst,
   input  wire utx_pkg::utx_wbreq_t wbReq,
   output utx_pkg::utx_wbrsp_t     wbRsp,
   input  wire logic               globalIrqEn,
   input  wire logic               doneIrqTaken,
   input  wire logic               portTxd,
   input  wire logic               portTxdOe,
   input  wire logic               xckPin,
   output logic                    txdOut,
   output logic                    txdOe,
   output logic                    xckOut,
   output logic                    xckOe,
   output logic                    irqBufEmpty,
   output logic                    irqTxDone
);
   import utx_pkg::*;

   // ************************************************************
   // Declarations
   // ************************************************************
   logic        ack_ff;          // Bus acknowledge
   logic [31:0] rdData_ff;       // Bus read data
   logic [7:0]  ctl_ff;          // Control register
   logic [8:0]  fmt_ff;          // Format register
   logic [11:0] baud_ff;         // Baud divisor
   logic        double_ff;       // Double speed bit
   logic [7:0]  buf_ff;          // Transmit buffer low byte
   logic        bufNinth_ff;     // Ninth bit caught with the byte
   logic        bufFull_ff;      // Buffer holds unsent data
   logic        done_ff;         // Transmit complete flag
   logic        txEnEff_ff;      // Effective transmitter enable
   utx_state_t  state_ff;        // Sequencer state
   logic [8:0]  shift_ff;        // Shift register
   logic [3:0]  bitCnt_ff;       // Data bits still to go
   logic        parity_ff;       // Parity of loaded character
   logic        line_ff;         // Serial line level
   utx_fmt_t    fmt;             // Format view
   logic        bitTick;         // One pulse per bit time
   logic        wbHit;           // New bus request
   logic        wrData;          // Data register write
   logic        wrStat;          // Status register write
   logic        wrCtl;           // Control register write
   logic        wrFmt;           // Format register write
   logic        wrBaud;          // Divisor write, restarts counter
   logic        lastStop;        // In the frame's final stop bit
   logic        shiftLoad;       // Buffer moves to shifter
   logic        doneSet;         // Frame finished, nothing queued
   logic [3:0]  nBits;           // Character length
   logic [8:0]  charData;        // Masked character
   logic [31:0] rdMux;           // Read data before the flop

   assign fmt = utx_fmt_t'(fmt_ff);

   // ************************************************************
   // Bit clock
   // ************************************************************
   utx_baud utx_baud_i (
      .sys_clk     (sys_clk),
      .sys_rst     (sys_rst),
      .divisor     (baud_ff),
      .divisorLoad (wrBaud),
      .doubleSpeed (double_ff),
      .fmt         (fmt),
      .xckPin      (xckPin),
      .xckOut      (xckOut),
      .xckOe       (xckOe),
      .bitTick     (bitTick)
   );

   // ************************************************************
   // Wishbone slave
   // ************************************************************
   // Answers every access one cycle later, mapped or not
   assign wbHit  = wbReq.cyc && wbReq.stb && !ack_ff;
   assign wrData = wbHit && wbReq.we && wbReq.sel[0] && (wbReq.adr == `UTX_OFS_DATA);
   assign wrStat = wbHit && wbReq.we && wbReq.sel[0] && (wbReq.adr == `UTX_OFS_STATUS);
   assign wrCtl  = wbHit && wbReq.we && wbReq.sel[0] && (wbReq.adr == `UTX_OFS_CONTROL);
   assign wrFmt  = wbHit && wbReq.we && (wbReq.adr == `UTX_OFS_FORMAT);
   assign wrBaud = wbHit && wbReq.we && (wbReq.adr == `UTX_OFS_BAUD);

   // Acknowledge drops the cycle after it was given
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= wbHit;
      end
   end

   // Read mux; unmapped offsets and the data register read zero
   always_comb begin
      rdMux = 32'h0000_0000;
      unique case (wbReq.adr)
         `UTX_OFS_STATUS: begin
            rdMux[`UTX_STAT_ACTIVE] = txEnEff_ff;
            rdMux[`UTX_STAT_DOUBLE] = double_ff;
            rdMux[`UTX_STAT_EMPTY]  = !bufFull_ff;           // R10
            rdMux[`UTX_STAT_DONE]   = done_ff;
         end
         `UTX_OFS_CONTROL: rdMux[7:0]  = ctl_ff;
         `UTX_OFS_FORMAT:  rdMux[8:0]  = fmt_ff;
         `UTX_OFS_BAUD:    rdMux[11:0] = baud_ff;
         default:          rdMux       = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdData_ff <= 32'h0000_0000;
      end else if (wbHit && !wbReq.we) begin
         rdData_ff <= rdMux;
      end
   end

   assign wbRsp.ack = ack_ff;
   assign wbRsp.dat = rdData_ff;

   // ************************************************************
   // Configuration registers
   // ************************************************************
   // Format changes mid-frame corrupt it; software must not do that
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctl_ff    <= `UTX_CTL_RESET;
         fmt_ff    <= `UTX_FMT_RESET;
         baud_ff   <= `UTX_BAUD_RESET;
         double_ff <= 1'b0;
      end else begin
         if (wrCtl) begin
            ctl_ff <= wbReq.dat[7:0];                        // R9
         end
         if (wrFmt && wbReq.sel[0]) begin
            fmt_ff[7:0] <= wbReq.dat[7:0];
         end
         if (wrFmt && wbReq.sel[1]) begin
            fmt_ff[8] <= wbReq.dat[8];
         end
         if (wrBaud && wbReq.sel[0]) begin
            baud_ff[7:0] <= wbReq.dat[7:0];
         end
         if (wrBaud && wbReq.sel[1]) begin
            baud_ff[11:8] <= wbReq.dat[11:8];
         end
         if (wrStat) begin
            double_ff <= wbReq.dat[`UTX_STAT_DOUBLE];
         end
      end
   end

   // ************************************************************
   // Character shaping
   // ************************************************************
   // Size codes 4 to 6 are reserved and fall back to eight bits
   always_comb begin
      unique case (fmt.size)
         3'h0:           nBits = 4'h5;
         3'h1:           nBits = 4'h6;
         3'h2:           nBits = 4'h7;
         `UTX_SIZE_NINE: nBits = 4'h9;
         default:        nBits = 4'h8;
      endcase
   end

   // High bits beyond the character length are dropped
   assign charData = {bufNinth_ff, buf_ff} & (9'h1FF >> (4'h9 - nBits));   // R8 R9
   assign lastStop = ((state_ff == ST_STOP1) && !fmt.stop) || (state_ff == ST_STOP2);
   assign shiftLoad = bitTick && bufFull_ff && txEnEff_ff
                      && ((state_ff == ST_IDLE) || lastStop);          // R6
   assign doneSet  = bitTick && lastStop && !bufFull_ff;              // R14

   // ************************************************************
   // Transmit buffer
   // ************************************************************
   // A write in the same cycle as a move keeps the buffer full
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         buf_ff      <= 8'h00;
         bufNinth_ff <= 1'b0;
         bufFull_ff  <= 1'b0;                                // R25
      end else if (wrData) begin
         buf_ff      <= wbReq.dat[7:0];                      // R5
         bufNinth_ff <= ctl_ff[`UTX_CTL_NINTH];              // R9
         bufFull_ff  <= 1'b1;                                // R11
      end else if (shiftLoad) begin
         bufFull_ff  <= 1'b0;                                // R10
      end
   end

   // ************************************************************
   // Transmit complete flag
   // ************************************************************
   // Setting wins over the interrupt or write-one clear
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         done_ff <= 1'b0;                                    // R25
      end else if (doneSet) begin
         done_ff <= 1'b1;                                    // R14
      end else if (doneIrqTaken || (wrStat && wbReq.dat[`UTX_STAT_DONE])) begin
         done_ff <= 1'b0;                                    // R15
      end
   end

   // ************************************************************
   // Effective enable
   // ************************************************************
   // Clearing the bit is deferred until nothing is left to send
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         txEnEff_ff <= 1'b0;
      end else if (ctl_ff[`UTX_CTL_TRANSMITTER_ENABLE]) begin
         txEnEff_ff <= 1'b1;
      end else if ((state_ff == ST_IDLE) && !bufFull_ff) begin
         txEnEff_ff <= 1'b0;                                 // R17
      end
   end

   // ************************************************************
   // Frame sequencer
   // ************************************************************
   // Every step waits for a bit pulse, so bits are full length
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff  <= ST_IDLE;
         shift_ff  <= 9'h000;
         bitCnt_ff <= 4'h0;
         parity_ff <= 1'b0;
         line_ff   <= 1'b1;                                  // R22
      end else if (bitTick) begin
         unique case (state_ff)
            ST_IDLE: begin
               line_ff <= 1'b1;
            end
            ST_START: begin
               state_ff  <= ST_DATA;
               line_ff   <= shift_ff[0];                     // R22
               shift_ff  <= {1'b0, shift_ff[8:1]};
               bitCnt_ff <= nBits;
            end
            ST_DATA: begin
               if (bitCnt_ff != 4'h1) begin
                  line_ff   <= shift_ff[0];
                  shift_ff  <= {1'b0, shift_ff[8:1]};
                  bitCnt_ff <= bitCnt_ff - 4'h1;
               end else if (fmt.parity[1]) begin
                  state_ff <= ST_PARITY;                     // R2
                  line_ff  <= parity_ff;
               end else begin
                  state_ff <= ST_STOP1;
                  line_ff  <= 1'b1;
               end
            end
            ST_PARITY: begin
               state_ff <= ST_STOP1;
               line_ff  <= 1'b1;                             // R22
            end
            ST_STOP1: begin
               if (fmt.stop) begin
                  state_ff <= ST_STOP2;
                  line_ff  <= 1'b1;
               end else begin
                  state_ff <= ST_IDLE;
                  line_ff  <= 1'b1;
               end
            end
            ST_STOP2: begin
               state_ff <= ST_IDLE;
               line_ff  <= 1'b1;
            end
            default: begin
               state_ff <= ST_IDLE;
               line_ff  <= 1'b1;
            end
         endcase
         // Back to back frames: the load overrides the step to idle
         if (shiftLoad) begin
            state_ff  <= ST_START;                           // R6 R7
            line_ff   <= 1'b0;                               // R22
            shift_ff  <= charData;
            parity_ff <= (^charData) ^ fmt.parity[0];        // R1
         end
      end
   end

   // ************************************************************
   // Pins and interrupt requests
   // ************************************************************
   assign txdOut = txEnEff_ff ? line_ff : portTxd;          // R3 R18
   assign txdOe  = txEnEff_ff ? 1'b1 : portTxdOe;           // R3 R18
   assign irqBufEmpty = globalIrqEn && ctl_ff[`UTX_CTL_EMPTYIE] && !bufFull_ff;  // R12
   assign irqTxDone   = globalIrqEn && ctl_ff[`UTX_CTL_DONEIE] && done_ff;       // R16

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   parity_bit_a: assert property (state_ff == ST_PARITY |-> line_ff == parity_ff) // R1
      else $error("parity bit level wrong");
   parity_place_a: assert property (bitTick && state_ff == ST_DATA && bitCnt_ff == 4'h1 // R2
      && fmt.parity[1] |=> state_ff == ST_PARITY)
      else $error("parity not after last data bit");
   pin_take_a: assert property (txEnEff_ff |-> txdOe && txdOut == line_ff) // R3
      else $error("serial pin not driven by transmitter");
   buf_load_a: assert property (wrData |=> bufFull_ff) // R11
      else $error("data write did not fill buffer");
   move_idle_a: assert property (shiftLoad |=> state_ff == ST_START && !line_ff // R6
      && (!bufFull_ff || $past(wrData)))
      else $error("buffer not moved into shifter");
   done_set_a: assert property (doneSet |=> done_ff ##1 (done_ff || $past(doneIrqTaken) // R14
      || $past(wrStat)))
      else $error("complete flag not set");
   done_clr_a: assert property (done_ff && doneIrqTaken && !doneSet |=> !done_ff) // R15
      else $error("complete flag not cleared");
   disable_hold_a: assert property (txEnEff_ff && (state_ff != ST_IDLE) |=> txEnEff_ff) // R17
      else $error("transmitter disabled mid frame");
   start_bit_a: assert property ($rose(state_ff == ST_START) |-> !line_ff // R22
      ##1 (!line_ff || state_ff != ST_START))
      else $error("start bit not low");

   parity_frame_c: cover property (state_ff == ST_PARITY ##[1:1000] state_ff == ST_STOP1);
   two_stop_c:     cover property (state_ff == ST_STOP2);
   back_to_back_c: cover property (lastStop && shiftLoad);
   irq_clear_c:    cover property (done_ff && doneIrqTaken);

endmodule : utx_transmitter

// [tb/utx_rx_model.sv]
`timescale 1ns/1ps

// ****
// Remote receiver on the serial line
// ****
module utx_rx_model (
   input  wire logic        sys_clk,
   input  wire logic        line,
   input  wire logic [3:0]  nBits,
   output logic      [11:0] frame,
   output logic      [7:0]  frameCnt
);
   // Samples mid-bit, 16 clocks a bit at divisor zero; bit 0 is the start bit
   initial begin
      frame = 12'h000;
      frameCnt = 8'h00;
      forever begin
         @(negedge line);
         frame = 12'h000;
         for (int i = 0; i < nBits; i++) begin
            repeat (i == 0 ? 8 : 16) @(posedge sys_clk);
            frame[i] = line;
         end
         frameCnt = frameCnt + 8'h01;
      end
   end
endmodule : utx_rx_model

// [tb/usart_transmitter_test.sv]
`timescale 1ns/1ps
`include "utx_regs.svh"

module usart_transmitter_test;
   import utx_pkg::*;
   logic        sys_clk = 1'b0;     // 25 MHz
   logic        sys_rst = 1'b1;     // Async, active high
   utx_wbreq_t  wbReq = '0;         // Bus request
   utx_wbrsp_t  wbRsp;
   logic        doneIrqTaken = 1'b0;
   logic        txdOut, txdOe, irqBufEmpty, irqTxDone;
   logic        xckOut, xckOe;
   logic        globalIrqEn = 1'b0;  // Masked during setup
   logic [31:0] sx = 32'h0;         // Expected double speed status bit
   logic [3:0]  rxBits = 4'hA;      // Bits the receiver collects
   logic [11:0] frame;
   logic [7:0]  frameCnt;
   logic [31:0] q;                  // Last read data
   int          badCount = 0;
   int          checksDone = 0;
   int          tick = 0;

   always #20 sys_clk = ~sys_clk;

   utx_transmitter utx_transmitter_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .wbReq(wbReq),
      .wbRsp(wbRsp), .globalIrqEn(globalIrqEn), .doneIrqTaken(doneIrqTaken), .portTxd(1'b1),
      .portTxdOe(1'b0), .xckPin(1'b0), .txdOut(txdOut), .txdOe(txdOe), .xckOut(xckOut),
      .xckOe(xckOe), .irqBufEmpty(irqBufEmpty), .irqTxDone(irqTxDone));

   utx_rx_model utx_rx_model_i (.sys_clk(sys_clk), .line(txdOut), .nBits(rxBits),
      .frame(frame), .frameCnt(frameCnt));

   // Hang guard, well above seven frames
   always @(posedge sys_clk) begin
      tick++;
      if (tick == 20000) begin
         badCount++;
         wrap_up();
      end
   end

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checksDone, badCount);
      if (badCount == 0 && checksDone > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checksDone++;
      if (g !== e) begin
         badCount++;
         $display("CHECK FAILED %0t got %h want %h", $time, g, e);
      end
   endtask : chk

   // Classic cycle; held until ack is seen high at an edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      wbReq <= '{1'b1, 1'b1, w, a, 4'hF, d};
      do begin
         @(posedge sys_clk);
      end while (wbRsp.ack !== 1'b1);
      q = wbRsp.dat;
      wbReq <= '0;
      @(posedge sys_clk);
   endtask : wb

   // One frame, enable dropped while it is still pending
   task automatic frameCase(input logic [8:0] f, input logic [7:0] c, input logic [7:0] d,
                            input logic [3:0] nb, input logic [11:0] e);
      logic [7:0] k;
      k = frameCnt;
      rxBits = nb;
      wb(1'b1, `UTX_OFS_FORMAT, {23'h0, f});
      wb(1'b1, `UTX_OFS_CONTROL, {24'h0, c});
      wb(1'b1, `UTX_OFS_DATA, {24'h0, d});
      wb(1'b1, `UTX_OFS_CONTROL, {24'h0, c & 8'hF7});
      wb(1'b0, `UTX_OFS_STATUS, 32'h0);
      chk(q[0], 1'b1);
      chk(txdOe, 1'b1);
      wait (frameCnt != k);
      chk(frame, e);
      repeat (24) @(posedge sys_clk);
      wb(1'b0, `UTX_OFS_STATUS, 32'h0);
      chk(q, 32'h60 | sx);
      chk(txdOe, 1'b0);
      chk({irqBufEmpty, irqTxDone}, 2'b11);
      if (c[0]) begin
         wb(1'b1, `UTX_OFS_STATUS, 32'h40);
      end else begin
         doneIrqTaken <= 1'b1;
         @(posedge sys_clk);
         doneIrqTaken <= 1'b0;
         @(posedge sys_clk);
      end
      wb(1'b0, `UTX_OFS_STATUS, 32'h0);
      chk(q, 32'h20 | sx);
   endtask : frameCase

   initial begin
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      wb(1'b0, `UTX_OFS_STATUS, 32'h0);
      chk(q, 32'h20);
      wb(1'b1, `UTX_OFS_BAUD, 32'h0);
      wb(1'b1, `UTX_OFS_CONTROL, 32'h20);
      chk(irqBufEmpty, 1'b0);
      globalIrqEn <= 1'b1;
      @(posedge sys_clk);
      chk(irqBufEmpty, 1'b1);
      frameCase(9'h003, 8'h68, 8'hA5, 4'hA, 12'h34A);
      frameCase(9'h022, 8'h68, 8'hB3, 4'hA, 12'h266);
      frameCase(9'h032, 8'h68, 8'hB3, 4'hA, 12'h366);
      frameCase(9'h007, 8'h69, 8'h5A, 4'hB, 12'h6B4);
      frameCase(9'h008, 8'h68, 8'hE6, 4'h8, 12'h0CC);
      // Sync master, divisor 7 gives 16 clocks a bit
      wb(1'b1, `UTX_OFS_BAUD, 32'h7);
      frameCase(9'h143, 8'h68, 8'hA5, 4'hA, 12'h34A);
      chk(xckOe, 1'b1);
      q[0] = xckOut;
      repeat (8) @(posedge sys_clk);
      chk(xckOut, !q[0]);
      // Double speed, divisor 1 also gives 16 clocks a bit
      wb(1'b1, `UTX_OFS_BAUD, 32'h1);
      wb(1'b1, `UTX_OFS_STATUS, 32'h2);
      sx = 32'h2;
      frameCase(9'h003, 8'h68, 8'hA5, 4'hA, 12'h34A);
      wrap_up();
   end
endmodule : usart_transmitter_test
